// ==== rtl/fpd_map.vh ====
// Constants for the floppy controller power sequencer
//
// How it works
// - Config zero bit 3 forces direct powerdown
// - Config seven bit 7 enables auto powerdown
// - Idle timer starts when auto mode enables
// - Status or data access reloads idle timer
// - Auto entry needs motors off, idle, unload, timeout
// - Clearing auto enable cancels timer and entry
// - Rate-select powerdown overrides auto; auto resumes after
// - Hardware or software reset wakes, runs reset
// - Motor enable write wakes from auto powerdown; control read does not
// - Status read or data access wakes from auto powerdown
// - Access wake keeps all state intact
// - Any wake restarts 10 ms idle timer
// - Registers stay readable and writable while down
// - Reset bit writes wake; other bits besides motor bits do not
// - Other listed accesses leave power state alone
// - Motor, select and write pins disabled, host pins kept active
// - Interrupt and DMA request held low while down
// - Power-good pin gives chip-level hardware powerdown
// - Motor, select, write pins float; others stay active
`ifndef FPD_MAP_VH
`define FPD_MAP_VH

// ****************************************************
// Register offsets
// ****************************************************
`define FPD_OFS_STATUS_A 3'h0
`define FPD_OFS_STATUS_B 3'h1
`define FPD_OFS_DIG_OUT 3'h2
`define FPD_OFS_RATE_MAIN 3'h4
`define FPD_OFS_FIFO 3'h5
`define FPD_OFS_DIN_CCR 3'h7

// ****************************************************
// Field positions
// ****************************************************
`define FPD_CR0_PWR_BIT 3
`define FPD_CR7_AUTO_BIT 7
`define FPD_DOR_MOTOR_HI 7
`define FPD_DOR_MOTOR_LO 4
`define FPD_DOR_RESET_N_BIT 2
`define FPD_DOR_SEL_HI 1
`define FPD_DOR_SEL_LO 0
`define FPD_DSR_RESET_BIT 7
`define FPD_DSR_PD_BIT 6
`define FPD_RATE_HI 1
`define FPD_RATE_LO 0

// ****************************************************
// Values and timing
// ****************************************************
`define FPD_MSR_IDLE 8'h80
`define FPD_DOR_RESET_VAL 8'h04
`define FPD_RATE_RESET_VAL 2'h0
`define FPD_BYTE_ZERO 8'h00
`define FPD_IDLE_MS 10
`define FPD_CLK_KHZ 250000
`define FPD_TMR_W 22
// Ten milliseconds of a 250 MHz clock, sized to the timer width
`define FPD_IDLE_CYCLES 22'h2625a0

`endif

// ==== rtl/fpd_idle_timer.v ====
// Down-counting idle timer for auto powerdown
`timescale 1ns/1ps
`include "fpd_map.vh"
module fpd_idle_timer #(
  parameter [21:0] LOAD_VAL = `FPD_IDLE_CYCLES
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Control
  input wire run,
  input wire reload,
  // Status
  output reg expired_reg
);

  reg [21:0] cnt_reg;
  reg [21:0] cnt_next;

  // Held at full count while stopped, so a fresh start always waits the full interval
  always @*
  begin
    cnt_next = cnt_reg;
    if (!run || reload)
      cnt_next = LOAD_VAL;
    else if (cnt_reg != 22'h000000)
      cnt_next = cnt_reg - 22'h000001;
  end

  // Counter and expiry flag
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg <= 22'h000000;
      expired_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      expired_reg <= run && !reload && (cnt_next == 22'h000000);
    end
  end

endmodule // fpd_idle_timer

// ==== rtl/fpd_power_ctl.v ====
// Floppy controller power sequencer: host registers, wake logic, pin gating
`timescale 1ns/1ps
`include "fpd_map.vh"
module fpd_power_ctl #(
  parameter [21:0] IDLE_CYCLES = `FPD_IDLE_CYCLES
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Host register port
  input wire [2:0] host_addr,
  input wire host_rd_stb,
  input wire host_wr_stb,
  input wire [7:0] host_wdata,
  output reg [7:0] host_rdata,
  // Configuration and chip power
  input wire [7:0] config_reg_zero,
  input wire [7:0] config_reg_seven,
  input wire power_good_in,
  // Controller core status
  input wire [7:0] status_a_in,
  input wire [7:0] status_b_in,
  input wire [7:0] main_status_in,
  input wire [7:0] fifo_rdata_in,
  input wire [7:0] digital_input_in,
  input wire core_irq_in,
  input wire core_dma_req_in,
  input wire head_unload_done_in,
  // Controller core drive-side requests
  input wire core_write_data_in,
  input wire core_write_enable_in,
  input wire core_direction_in,
  input wire core_step_in,
  input wire core_head_sel_in,
  input wire core_density_in,
  // Controller core control
  output reg core_soft_reset,
  output reg fifo_rd_stb,
  output reg fifo_wr_stb,
  output reg [7:0] fifo_wdata,
  output reg powered_down,
  // Host-side outputs
  output reg floppy_irq_out,
  output reg floppy_dma_req_out,
  // Drive-side outputs
  output reg [3:0] motor_enable_out,
  output reg [3:0] motor_enable_oe,
  output reg [3:0] drive_select_out,
  output reg [3:0] drive_select_oe,
  output reg write_data_out,
  output reg write_data_oe,
  output reg write_enable_out,
  output reg write_enable_oe,
  output reg direction_out,
  output reg step_out,
  output reg head_sel_out,
  output reg density_out,
  output reg [1:0] data_rate_out
);

  // ****************************************************
  // Decode helpers
  // ****************************************************

  // Address match used by every strobe decode below
  function hit;
    input [2:0] addr;
    input [2:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // Motor field test, shared by the wake decode and the idle test
  function any_motor;
    input [7:0] ctl;
    begin
      any_motor = |ctl[`FPD_DOR_MOTOR_HI:`FPD_DOR_MOTOR_LO];
    end
  endfunction

  // Drive select match for one lane; only the low lane bits take part
  function sel_match;
    input [1:0] sel;
    input integer lane;
    begin
      sel_match = (sel == lane[1:0]);
    end
  endfunction

  // ****************************************************
  // State
  // ****************************************************
  // Stored register and power state
  reg [7:0] dor_reg;
  reg [1:0] rate_reg;
  reg dsr_pd_reg;
  reg auto_pd_reg;
  reg auto_en_d_reg;

  // Next values
  reg [7:0] dor_next;
  reg [1:0] rate_next;
  reg dsr_pd_next;
  reg auto_pd_next;
  reg [7:0] rdata_next;

  // Decoded strobes and conditions
  wire auto_en;
  wire direct_pd;
  wire wr_dor;
  wire wr_dsr;
  wire wr_ccr;
  wire rd_msr;
  wire rd_fifo;
  wire wr_fifo;
  wire acc_fifo;
  wire motor_wake;
  wire dor_reset;
  wire dsr_reset;
  wire dsr_pd_req;
  wire soft_reset;
  wire access_wake;
  wire any_wake;
  wire idle_cond;
  wire tmr_reload;
  wire tmr_expired;
  wire pd_any;

  // ****************************************************
  // Access decode
  // ****************************************************

  // Enables from the configuration registers
  assign direct_pd = config_reg_zero[`FPD_CR0_PWR_BIT];
  assign auto_en = config_reg_seven[`FPD_CR7_AUTO_BIT];

  // Host strobes by offset; offset 4 is rate select on write, main status on read
  assign wr_dor = host_wr_stb && hit(host_addr, `FPD_OFS_DIG_OUT);
  assign wr_dsr = host_wr_stb && hit(host_addr, `FPD_OFS_RATE_MAIN);
  assign wr_ccr = host_wr_stb && hit(host_addr, `FPD_OFS_DIN_CCR);
  assign rd_msr = host_rd_stb && hit(host_addr, `FPD_OFS_RATE_MAIN);
  assign rd_fifo = host_rd_stb && hit(host_addr, `FPD_OFS_FIFO);
  assign wr_fifo = host_wr_stb && hit(host_addr, `FPD_OFS_FIFO);
  assign acc_fifo = rd_fifo || wr_fifo;

  // Motor wake only when a written motor bit is one; reads of the control register never wake
  assign motor_wake = wr_dor && any_motor(host_wdata);

  // Software reset through either reset bit; of the other bits of these writes only the motor bits wake
  assign dor_reset = wr_dor && !host_wdata[`FPD_DOR_RESET_N_BIT];
  assign dsr_reset = wr_dsr && host_wdata[`FPD_DSR_RESET_BIT];
  assign soft_reset = dor_reset || dsr_reset;

  // Rate-select powerdown request; a reset in the same write cancels it
  assign dsr_pd_req = wr_dsr && host_wdata[`FPD_DSR_PD_BIT];

  // Only these accesses leave the sleeping state; all others are ignored here
  assign access_wake = motor_wake || rd_msr || acc_fifo;
  assign any_wake = access_wake || soft_reset;

  // Idle controller: motors off, status idle, no interrupt, head unloaded
  assign idle_cond = !any_motor(dor_reg)
    && (main_status_in == `FPD_MSR_IDLE) && !core_irq_in
    && head_unload_done_in;

  // Timer restarts on enable edge, on status or data traffic and on any wake
  assign tmr_reload = (auto_en && !auto_en_d_reg) || rd_msr || acc_fifo
    || any_wake;

  // Every source of powerdown, including the chip-level power-good pin
  assign pd_any = direct_pd || dsr_pd_reg || auto_pd_reg || !power_good_in;

  // ****************************************************
  // Idle timer
  // ****************************************************

  // Interval in cycles comes from the parameter, so simulation can shorten it
  fpd_idle_timer #(
    .LOAD_VAL(IDLE_CYCLES)
  ) u_idle_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(auto_en),
    .reload(tmr_reload),
    .expired_reg(tmr_expired)
  );

  // ****************************************************
  // Register and power state next values
  // ****************************************************

  // Writes are retained in any power state; wake by access changes no stored value
  always @*
  begin
    dor_next = dor_reg;
    rate_next = rate_reg;
    dsr_pd_next = dsr_pd_reg;
    auto_pd_next = auto_pd_reg;
    if (wr_dor)
      dor_next = host_wdata;
    if (wr_dsr)
      rate_next = host_wdata[`FPD_RATE_HI:`FPD_RATE_LO];
    if (wr_ccr)
      rate_next = host_wdata[`FPD_RATE_HI:`FPD_RATE_LO];
    // Rate-select powerdown only ends on a software reset or a hardware reset
    if (dsr_pd_req)
      dsr_pd_next = 1'b1;
    if (soft_reset)
    begin
      dsr_pd_next = 1'b0;
      rate_next = `FPD_RATE_RESET_VAL;
    end
    // Auto entry is held off while rate-select powerdown owns the controller
    if (auto_en && idle_cond && tmr_expired && !dsr_pd_reg && !tmr_reload)
      auto_pd_next = 1'b1;
    // Wake wins over entry in the same cycle; nothing else is touched
    if (any_wake || !auto_en || dsr_pd_reg)
      auto_pd_next = 1'b0;
  end

  // Read data mux; true contents are returned whatever the power state
  always @*
  begin
    case (host_addr)
      `FPD_OFS_STATUS_A: rdata_next = status_a_in;
      `FPD_OFS_STATUS_B: rdata_next = status_b_in;
      `FPD_OFS_DIG_OUT: rdata_next = dor_reg;
      `FPD_OFS_RATE_MAIN: rdata_next = main_status_in;
      `FPD_OFS_FIFO: rdata_next = fifo_rdata_in;
      `FPD_OFS_DIN_CCR: rdata_next = digital_input_in;
      default: rdata_next = `FPD_BYTE_ZERO;
    endcase
  end

  // ****************************************************
  // Clocked state
  // ****************************************************

  // Hardware reset returns every register to its reset value and wakes the block
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      dor_reg <= `FPD_DOR_RESET_VAL;
      rate_reg <= `FPD_RATE_RESET_VAL;
      dsr_pd_reg <= 1'b0;
      auto_pd_reg <= 1'b0;
      auto_en_d_reg <= 1'b0;
    end
    else
    begin
      dor_reg <= dor_next;
      rate_reg <= rate_next;
      dsr_pd_reg <= dsr_pd_next;
      auto_pd_reg <= auto_pd_next;
      auto_en_d_reg <= auto_en;
    end
  end

  // Host-side outputs stay live so waking accesses still get answers
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      host_rdata <= `FPD_BYTE_ZERO;
      core_soft_reset <= 1'b0;
      fifo_rd_stb <= 1'b0;
      fifo_wr_stb <= 1'b0;
      fifo_wdata <= `FPD_BYTE_ZERO;
      powered_down <= 1'b0;
      floppy_irq_out <= 1'b0;
      floppy_dma_req_out <= 1'b0;
    end
    else
    begin
      host_rdata <= rdata_next;
      core_soft_reset <= soft_reset;
      fifo_rd_stb <= rd_fifo;
      fifo_wr_stb <= wr_fifo;
      fifo_wdata <= host_wdata;
      powered_down <= pd_any;
      // Held low while down so a stale request cannot reach the host
      floppy_irq_out <= core_irq_in && !pd_any;
      floppy_dma_req_out <= core_dma_req_in && !pd_any;
    end
  end

  // ****************************************************
  // Drive-side pins
  // ****************************************************

  // Floating pins draw no current from a drive powered beyond our rails
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_drive
      always @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          motor_enable_out[i] <= 1'b0;
          motor_enable_oe[i] <= 1'b0;
          drive_select_out[i] <= 1'b0;
          drive_select_oe[i] <= 1'b0;
        end
        else
        begin
          motor_enable_out[i] <= dor_reg[`FPD_DOR_MOTOR_LO + i];
          motor_enable_oe[i] <= !pd_any;
          drive_select_out[i] <= sel_match(dor_reg[`FPD_DOR_SEL_HI:`FPD_DOR_SEL_LO], i);
          drive_select_oe[i] <= !pd_any;
        end
      end
    end
  endgenerate

  // Write path floats while down; positioning and rate pins stay driven
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      write_data_out <= 1'b0;
      write_data_oe <= 1'b0;
      write_enable_out <= 1'b0;
      write_enable_oe <= 1'b0;
      direction_out <= 1'b0;
      step_out <= 1'b0;
      head_sel_out <= 1'b0;
      density_out <= 1'b0;
      data_rate_out <= `FPD_RATE_RESET_VAL;
    end
    else
    begin
      write_data_out <= core_write_data_in;
      write_data_oe <= !pd_any;
      write_enable_out <= core_write_enable_in;
      write_enable_oe <= !pd_any;
      direction_out <= core_direction_in;
      step_out <= core_step_in;
      head_sel_out <= core_head_sel_in;
      density_out <= core_density_in;
      data_rate_out <= rate_reg;
    end
  end

endmodule // fpd_power_ctl

// ==== tb/fpd_core_model.sv ====
// Behavioural model of the controller core and drive beside the sequencer
`timescale 1ns/1ps
module fpd_core_model (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Core read values and drive-side requests
  output logic [7:0] status_a_in,
  output logic [7:0] status_b_in,
  output logic [7:0] fifo_rdata_in,
  output logic [7:0] digital_input_in,
  output logic core_dma_req_in,
  output logic core_write_data_in,
  output logic core_write_enable_in,
  output logic core_direction_in,
  output logic core_step_in,
  output logic core_head_sel_in,
  output logic core_density_in
);
  logic [7:0] lfsr_reg;
  // Values move every cycle so a stale read can never pass for a fresh one
  always @(posedge ref_clk or posedge rst)
    if (rst)
      lfsr_reg <= 8'h5a;
    else
      lfsr_reg <= #1 {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
  // Every output is a different view of the same pattern
  assign status_a_in = lfsr_reg;
  assign status_b_in = ~lfsr_reg;
  assign fifo_rdata_in = lfsr_reg ^ 8'h3c;
  assign digital_input_in = {lfsr_reg[3:0], lfsr_reg[7:4]};
  assign {core_dma_req_in, core_write_data_in, core_write_enable_in, core_direction_in,
    core_step_in, core_head_sel_in, core_density_in} = lfsr_reg[6:0];
endmodule // fpd_core_model

// ==== tb/fpd_power_ctl_properties.sv ====
// Port checker for the floppy power sequencer
`timescale 1ns/1ps
module fpd_power_props #(
  parameter [21:0] IDLE_CYCLES = 22'h000014
) (
  // Clock, reset and host port
  input wire ref_clk,
  input wire rst,
  input wire [2:0] host_addr,
  input wire host_rd_stb,
  input wire host_wr_stb,
  input wire [7:0] host_wdata,
  // Power and core inputs
  input wire [7:0] config_reg_zero,
  input wire power_good_in,
  input wire core_direction_in,
  input wire core_step_in,
  input wire core_write_data_in,
  input wire core_write_enable_in,
  input wire core_head_sel_in,
  input wire core_density_in,
  input wire core_dma_req_in,
  // Outputs
  input wire core_soft_reset,
  input wire fifo_rd_stb,
  input wire fifo_wr_stb,
  input wire [7:0] fifo_wdata,
  input wire powered_down,
  input wire floppy_irq_out,
  input wire floppy_dma_req_out,
  input wire [3:0] motor_enable_oe,
  input wire [3:0] drive_select_oe,
  input wire write_data_oe,
  input wire write_enable_oe,
  input wire direction_out,
  input wire step_out,
  input wire write_data_out,
  input wire write_enable_out,
  input wire head_sel_out,
  input wire density_out
);
  // ****************************************************
  // Properties
  // ****************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // Host-side requests must not leak out of a sleeping controller
  a_irq_gated: assert property (powered_down |-> !floppy_irq_out && !floppy_dma_req_out)
    else $error("interrupt or dma request high while down");
  a_drive_float: assert property (powered_down |-> motor_enable_oe == 4'h0 &&
    drive_select_oe == 4'h0 && !write_data_oe && !write_enable_oe)
    else $error("drive pin enabled while down");
  a_pins_active: assert property (powered_down && $past(powered_down) |->
    {direction_out, step_out} == $past({core_direction_in, core_step_in}))
    else $error("direction or step frozen while down");
  a_direct_pd: assert property ($rose(config_reg_zero[3]) |-> ##[1:3] powered_down)
    else $error("direct powerdown not taken");
  a_pgood_pd: assert property ($fell(power_good_in) |-> ##[1:3] powered_down)
    else $error("power good loss not taken");
  a_rate_pd: assert property (host_wr_stb && host_addr == 3'h4 &&
    host_wdata[7:6] == 2'b01 |-> ##[1:3] powered_down)
    else $error("rate select powerdown not taken");
  a_fifo_strobe: assert property (host_rd_stb && host_addr == 3'h5 |=> fifo_rd_stb)
    else $error("data port read not passed on");
  a_soft_reset: assert property (host_wr_stb && (host_addr == 3'h4 && host_wdata[7] ||
    host_addr == 3'h2 && !host_wdata[2]) |=> core_soft_reset)
    else $error("software reset not issued");
  a_drive_on: assert property (!powered_down && !$past(rst) |->
    motor_enable_oe == 4'hf && drive_select_oe == 4'hf && write_data_oe && write_enable_oe)
    else $error("drive pin disabled while awake");
  a_write_path: assert property (!$past(rst) |-> {write_data_out, write_enable_out,
    head_sel_out, density_out} == $past({core_write_data_in, core_write_enable_in,
    core_head_sel_in, core_density_in}))
    else $error("drive pin value not passed on");
  a_dma_pass: assert property (!powered_down && !$past(rst) |->
    floppy_dma_req_out == $past(core_dma_req_in))
    else $error("dma request not passed on while awake");
  a_fifo_write: assert property (host_wr_stb && host_addr == 3'h5 |=>
    fifo_wr_stb && fifo_wdata == $past(host_wdata))
    else $error("data port write not passed on");
  c_enter: cover property ($rose(powered_down));
  c_wake: cover property ($fell(powered_down));
  c_read_down: cover property (powered_down && host_rd_stb);
endmodule // fpd_power_props

bind fpd_power_ctl fpd_power_props #(.IDLE_CYCLES(IDLE_CYCLES)) i_props (.*);

// ==== tb/fpd_power_ctl_tb.sv ====
// Self-checking bench for the floppy power sequencer
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module fpd_power_ctl_tb;
  localparam int IDLE = 20;
  logic ref_clk = 1'b0, rst = 1'b1, host_rd_stb = 1'b0, host_wr_stb = 1'b0;
  logic power_good_in = 1'b1, core_irq_in = 1'b0, head_unload_done_in = 1'b1, rd_q = 1'b0;
  logic [2:0] host_addr = 3'h0;
  logic [7:0] host_wdata = 8'h00, config_reg_zero = 8'h00, config_reg_seven = 8'h00;
  logic [7:0] main_status_in = 8'h80, dor_exp = 8'h04, r8, exp_b;
  logic [7:0] expq[$];
  int n_mismatch = 0, n_tests = 0, i;
  wire [7:0] host_rdata, fifo_wdata, status_a_in, status_b_in, fifo_rdata_in, digital_input_in;
  wire [3:0] motor_enable_out, motor_enable_oe, drive_select_out, drive_select_oe;
  wire [1:0] data_rate_out;
  wire core_soft_reset, fifo_rd_stb, fifo_wr_stb, powered_down, floppy_irq_out;
  wire floppy_dma_req_out, write_data_out, write_data_oe, write_enable_out, write_enable_oe;
  wire direction_out, step_out, head_sel_out, density_out, core_dma_req_in, core_write_data_in;
  wire core_write_enable_in, core_direction_in, core_step_in, core_head_sel_in, core_density_in;

  fpd_power_ctl #(.IDLE_CYCLES(22'(IDLE))) i_dut (.*);
  fpd_core_model i_core (.*);

  always #2 ref_clk = ~ref_clk;

  // ****************************************************
  // Tasks
  // ****************************************************
  task automatic conclude;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One access; a read notes its expected byte at the edge that takes it
  task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    host_rd_stb = !wr;
    host_wr_stb = wr;
    host_addr = a;
    host_wdata = d;
    @(posedge ref_clk);
    if (!wr)
      expq.push_back(a == 3'h0 ? status_a_in : a == 3'h1 ? status_b_in : a == 3'h2 ? dor_exp :
        a == 3'h4 ? main_status_in : a == 3'h5 ? fifo_rdata_in : a == 3'h7 ? digital_input_in :
        8'h00);
    else if (a == 3'h2)
      dor_exp = d;
    #1;
    host_rd_stb = 1'b0;
    host_wr_stb = 1'b0;
  endtask

  // Bounded wait for a power state; leaves the bench just past an edge
  task automatic wait_pd(input logic v, input int lim);
    for (int k = 0; k < lim && powered_down !== v; k++)
      @(posedge ref_clk);
    n_tests++;
    if (powered_down !== v)
    begin
      n_mismatch++;
      $display("ERROR %0t: power state wait ran out", $time);
      conclude();
    end
    else
      #1;
  endtask

  // The power state must stay put for n cycles
  task automatic hold(input logic v, input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      `CHK(powered_down, v)
    end
    #1;
  endtask

  // Read results are compared one cycle after the taking edge
  always @(posedge ref_clk)
  begin
    rd_q <= host_rd_stb;
    if (rd_q)
    begin
      exp_b = expq.pop_front();
      `CHK(host_rdata, exp_b)
    end
  end

  initial
  begin
    #200000;
    n_mismatch++;
    $display("ERROR %0t: run took too long", $time);
    conclude();
  end

  // ****************************************************
  // Scenarios
  // ****************************************************
  initial
  begin
    void'($urandom(32'hbeabcc18));
    r8 = 8'($urandom);
    repeat (20) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    config_reg_seven = 8'h80;
    hold(1'b0, IDLE - 2);
    wait_pd(1'b1, 12);
    `CHK(motor_enable_oe, 4'h0)
    // Reads and writes that must not wake, with true values back
    for (i = 0; i < 8; i++)
      if (i != 4 && i != 5)
        bus(1'b0, i[2:0], 8'h00);
    bus(1'b1, 3'h2, 8'h04 | (r8 & 8'h03));
    bus(1'b1, 3'h4, r8 & 8'h3f);
    bus(1'b1, 3'h7, r8);
    bus(1'b1, 3'h6, r8);
    hold(1'b1, 3);
    `CHK(data_rate_out, r8[1:0])
    `CHK(drive_select_out, 4'h1 << r8[1:0])
    // Every waking access, then sleep again once the interval has run
    for (i = 0; i < 6; i++)
    begin
      wait_pd(1'b1, IDLE + 12);
      case (i)
        0: bus(1'b0, 3'h4, 8'h00);
        1: bus(1'b0, 3'h5, 8'h00);
        2: bus(1'b1, 3'h5, r8);
        3: bus(1'b1, 3'h2, 8'h14);
        4: bus(1'b1, 3'h2, 8'h00);
        default: bus(1'b1, 3'h4, 8'h80);
      endcase
      wait_pd(1'b0, 4);
      `CHK(data_rate_out, i >= 4 ? 2'h0 : r8[1:0])
      if (i == 3)
        `CHK({motor_enable_out, drive_select_out}, 8'h11)
      bus(1'b1, 3'h2, 8'h04);
      hold(1'b0, IDLE - 8);
    end
    // Any one missing entry condition keeps the controller awake
    for (i = 0; i < 4; i++)
    begin
      bus(1'b0, 3'h4, 8'h00);
      if (i == 3)
        bus(1'b1, 3'h2, 8'h14);
      wait_pd(1'b0, 4);
      main_status_in = i == 0 ? 8'h90 : 8'h80;
      core_irq_in = i == 1;
      head_unload_done_in = i != 2;
      hold(1'b0, IDLE + 8);
      main_status_in = 8'h80;
      core_irq_in = 1'b0;
      head_unload_done_in = 1'b1;
      bus(1'b1, 3'h2, 8'h04);
    end
    wait_pd(1'b1, IDLE + 12);
    config_reg_seven = 8'h00;
    wait_pd(1'b0, 4);
    hold(1'b0, IDLE + 8);
    // Rate-select powerdown outranks auto mode until a software reset
    config_reg_seven = 8'h80;
    wait_pd(1'b1, IDLE + 12);
    bus(1'b1, 3'h4, 8'h40);
    bus(1'b0, 3'h4, 8'h00);
    hold(1'b1, 4);
    bus(1'b1, 3'h4, 8'h80);
    wait_pd(1'b0, 4);
    wait_pd(1'b1, IDLE + 12);
    // Hardware reset in mid-run wakes the controller and restarts the timer
    rst = 1'b1;
    hold(1'b0, 2);
    rst = 1'b0;
    hold(1'b0, IDLE - 2);
    wait_pd(1'b1, 12);
    // Direct and chip-level powerdown, with the interrupt checked low under direct powerdown
    config_reg_seven = 8'h00;
    core_irq_in = 1'b1;
    wait_pd(1'b0, 4);
    `CHK(floppy_irq_out, 1'b1)
    config_reg_zero = 8'h08;
    wait_pd(1'b1, 4);
    `CHK(floppy_irq_out, 1'b0)
    config_reg_zero = 8'h00;
    wait_pd(1'b0, 4);
    power_good_in = 1'b0;
    wait_pd(1'b1, 4);
    power_good_in = 1'b1;
    wait_pd(1'b0, 4);
    conclude();
  end
endmodule // fpd_power_ctl_tb
